// File: tb_timer0_with_shared_prescaler.sv
// self-checking bench for the timer with shared prescaler
`timescale 1ns/10ps
module tb_timer0_with_shared_prescaler
  import twsp_pkg::*;
;
  localparam int PIN_BIT = 2; // count pin position in direction a
  logic       clk_i, sys_rst_i, wr, rd, opt_wr, tris_wr, wd_clr, wd_tick, ext_lvl, pin;
  logic       rvalid, wrap, wto, wake, pull;
  logic [4:0] addr;
  logic [7:0] wdata, rdata, count, c0;
  logic [5:0] dir_a, dir_c;
  int         bad_count, n_tests, n_wto, t, p;
  twsp_top #(.COUNT_PIN_BIT(PIN_BIT)) uut (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .file_addr_i(addr), .file_wr_i(wr),
    .file_rd_i(rd), .file_wdata_i(wdata), .option_wr_i(opt_wr), .tris_wr_i(tris_wr),
    .watchdog_clear_instr_i(wd_clr), .watchdog_tick_i(wd_tick),
    .external_count_input_i(pin), .file_rdata_o(rdata), .file_rvalid_o(rvalid),
    .timer_count_o(count), .timer_wrap_o(wrap), .watchdog_timeout_o(wto),
    .pin_direction_a_o(dir_a), .pin_direction_c_o(dir_c),
    .wake_on_change_disable_o(wake), .weak_pullup_disable_o(pull));
  twsp_pulse_src src (.clk_i(clk_i), .level_i(ext_lvl), .pin_o(pin));
  // clock and time-out tally
  always #(CLK_PERIOD_NS / 2) clk_i = ~clk_i;
  always @(posedge clk_i) begin
    if (!sys_rst_i && wto === 1'b1) n_wto <= n_wto + 1;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask : cyc
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // one-cycle strobe: 0 file write, 1 config, 2 direction, 3 wd clear, 4 wd tick
  task automatic op(input int k, input logic [4:0] a, input logic [7:0] d);
    @(negedge clk_i);
    addr    <= a;
    wdata   <= d;
    wr      <= (k == 0);
    opt_wr  <= (k == 1);
    tris_wr <= (k == 2);
    wd_clr  <= (k == 3);
    wd_tick <= (k == 4);
    @(negedge clk_i);
    {wr, opt_wr, tris_wr, wd_clr, wd_tick} <= 5'h00;
  endtask : op
  task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp);
    @(negedge clk_i);
    addr <= a;
    rd   <= 1'b1;
    @(negedge clk_i);
    rd <= 1'b0;
    chk({7'h00, rvalid}, 8'h01);
    chk(rdata, exp);
  endtask : rd_chk
  task automatic do_reset();
    sys_rst_i <= 1'b1;
    cyc(16);
    sys_rst_i <= 1'b0;
  endtask : do_reset
  // pulses on the pin, w cycles high and w low, then let the sampler settle
  task automatic pulses(input int n, input int w);
    repeat (n) begin
      ext_lvl <= 1'b1;
      cyc(w);
      ext_lvl <= 1'b0;
      cyc(w);
    end
    cyc(12);
  endtask : pulses
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  // hang guard, well above the roughly 7400 cycles the tests need
  initial begin
    #(30000 * CLK_PERIOD_NS);
    bad_count++;
    tally_and_finish();
  end
  initial begin
    {clk_i, sys_rst_i, wr, rd, opt_wr, tris_wr, wd_clr, wd_tick, ext_lvl} = 9'h080;
    {bad_count, n_tests, n_wto} = '0;
    addr = 5'h00;
    wdata = 8'h00;
    do_reset();
    // reset state, plain access and an unmapped address
    cyc(1);
    chk({2'h0, dir_a}, 8'h3f);
    chk({6'h00, wake, pull}, 8'h03);
    op(0, TIMER_COUNT_ADDR, 8'h5a);
    op(0, 5'h03, 8'h11);
    rd_chk(TIMER_COUNT_ADDR, 8'h5a);
    rd_chk(5'h02, 8'h00);
    op(2, DIR_A_ADDR, 8'h00);
    op(2, DIR_C_ADDR, 8'h00);
    chk({2'h0, dir_a}, 8'h01 << PIN_BIT);
    chk({2'h0, dir_c}, 8'h00);
    // internal clock: two held-off cycles after a write, then one step a cycle
    op(1, 5'h00, 8'h08);
    chk({2'h0, dir_a}, 8'h00);
    op(0, TIMER_COUNT_ADDR, 8'hfd);
    cyc(8);
    chk(count, 8'hfd);
    cyc(4);
    chk(count, 8'hfe);
    cyc(8);
    chk(count, 8'h00);
    cyc(40);
    chk(count, 8'h0a);
    // every prescale rate: a window of two periods holds exactly two steps
    for (int n = 0; n < 8; n++) begin
      p = 4 << (n + 1);
      op(1, 5'h00, 8'(n));
      op(0, TIMER_COUNT_ADDR, 8'h00);
      cyc(p + 16);
      c0 = count;
      cyc(2 * p);
      chk(count - c0, 8'h02);
    end
    // a second write clears the prescaler, so 128 ticks are never reached
    op(1, 5'h00, 8'h07);
    op(0, TIMER_COUNT_ADDR, 8'h00);
    cyc(400);
    op(0, TIMER_COUNT_ADDR, 8'h00);
    cyc(400);
    chk(count, 8'h00);
    // prescaler on the timer: each watchdog tick times out by itself
    t = n_wto;
    repeat (3) op(4, 5'h00, 8'h00);
    cyc(3);
    chk(8'(n_wto - t), 8'h03);
    // move the prescaler to the watchdog at rate 1, then reset and wd clear
    op(3, 5'h00, 8'h00);
    op(0, TIMER_COUNT_ADDR, 8'h00);
    op(1, 5'h00, 8'h0f);
    op(3, 5'h00, 8'h00);
    op(1, 5'h00, 8'h09);
    op(4, 5'h00, 8'h00);
    do_reset();
    op(1, 5'h00, 8'h09);
    t = n_wto;
    op(4, 5'h00, 8'h00);
    cyc(3);
    chk(8'(n_wto - t), 8'h00);
    repeat (2) op(4, 5'h00, 8'h00);
    op(3, 5'h00, 8'h00);
    repeat (2) op(4, 5'h00, 8'h00);
    cyc(3);
    chk(8'(n_wto - t), 8'h02);
    // external pin, no prescaler: only the selected edge steps the count
    for (int s = 0; s < 2; s++) begin
      op(1, 5'h00, {3'h1, 1'(s), 4'h8});
      op(0, TIMER_COUNT_ADDR, 8'h00);
      cyc(10);
      ext_lvl <= 1'b1;
      cyc(12);
      chk(count, 8'(1 - s));
      ext_lvl <= 1'b0;
      cyc(12);
      chk(count, 8'h01);
    end
    pulses(3, 2);
    chk(count, 8'h04);
    // pin through the prescaler at 1:2: eight pulses make four steps
    op(3, 5'h00, 8'h00);
    op(1, 5'h00, 8'h30);
    op(0, TIMER_COUNT_ADDR, 8'h00);
    cyc(10);
    pulses(8, 3);
    chk(count, 8'h04);
    tally_and_finish();
  end
endmodule : tb_timer0_with_shared_prescaler

// File: twsp_phase.sv
// phase divider: four phase clocks per instruction cycle, one-cycle enables
`timescale 1ns/10ps
module twsp_phase
  import twsp_pkg::*;
(
  input  wire logic clk_i,     // oscillator clock
  input  wire logic sys_rst_i, // synchronous reset, active high
  output logic      q2_o,      // pulse during phase two
  output logic      q4_o       // pulse during phase four, end of cycle
);
  typedef struct packed {
    twsp_phase_t phase;
  } twsp_phase_state_t;

  twsp_phase_state_t state_d;
  twsp_phase_state_t state_q;

  // phases advance one per clock; counter wraps after phase four
  always_comb begin
    state_d       = state_q;
    state_d.phase = twsp_phase_t'(2'(state_q.phase + 2'h1));
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_q.phase <= PH_Q1;
    end else begin
      state_q <= state_d;
    end
  end

  // sampling points of the synchroniser
  assign q2_o = (state_q.phase == PH_Q2);
  assign q4_o = (state_q.phase == PH_Q4);
endmodule : twsp_phase

// File: twsp_pkg.sv
// shared constants and types for the timer with shared prescaler
package twsp_pkg;
  // clk_i is the oscillator; one phase clock lasts one oscillator period
  localparam int CLK_PERIOD_NS    = 100;
  localparam int TOSC_NS          = 100;
  localparam int PHASES_PER_INSTR = 4;
  // external input timing in oscillator periods, and the same in clk cycles
  localparam int EXT_HALF_MIN_TOSC   = 2;
  localparam int EXT_PERIOD_MIN_TOSC = 4;
  localparam int INC_DELAY_MIN_TOSC  = 3;
  localparam int INC_DELAY_MAX_TOSC  = 7;
  localparam int EXT_HALF_MIN_CYC    =
    (EXT_HALF_MIN_TOSC * TOSC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int EXT_PERIOD_MIN_CYC  =
    (EXT_PERIOD_MIN_TOSC * TOSC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INC_DELAY_MIN_CYC   =
    (INC_DELAY_MIN_TOSC * TOSC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INC_DELAY_MAX_CYC   = (INC_DELAY_MAX_TOSC * TOSC_NS) / CLK_PERIOD_NS;
  // file register addresses
  localparam logic [4:0] TIMER_COUNT_ADDR = 5'h01;
  localparam logic [4:0] DIR_A_ADDR       = 5'h06;
  localparam logic [4:0] DIR_C_ADDR       = 5'h07;
  // configuration field positions
  localparam int OPT_WAKE_BIT = 7;
  localparam int OPT_PULL_BIT = 6;
  localparam int OPT_CSS_BIT  = 5;
  localparam int OPT_SES_BIT  = 4;
  localparam int OPT_PSA_BIT  = 3;
  localparam int OPT_RATE_LSB = 0;
  localparam int OPT_RATE_W   = 3;
  // values after reset
  localparam logic [7:0] OPTION_RST = 8'hff;
  localparam logic [5:0] DIR_RST    = 6'h3f;
  localparam logic [7:0] COUNT_RST  = 8'h00;
  localparam logic [7:0] PSC_RST    = 8'h00;
  // instruction cycles with counting held off after a count write
  localparam logic [1:0] WRITE_INHIBIT_CYCLES = 2'h2;
  // phase clocks of one instruction cycle
  typedef enum logic [1:0] {
    PH_Q1 = 2'b00,
    PH_Q2 = 2'b01,
    PH_Q3 = 2'b10,
    PH_Q4 = 2'b11
  } twsp_phase_t;
endpackage : twsp_pkg

// File: twsp_prescaler.sv
// shared prescaler: counter whose state leaves this module only as the selected tap bit
`timescale 1ns/10ps
module twsp_prescaler
  import twsp_pkg::*;
#(
  parameter int WIDTH = 8 // counter width
) (
  input  wire logic clk_i,     // oscillator clock
  input  wire logic sys_rst_i, // synchronous reset, active high
  twsp_psc_if.psc   psc        // tick, clear, rate select and tap
);
  typedef struct packed {
    logic [WIDTH-1:0] cnt;
  } twsp_psc_state_t;

  twsp_psc_state_t state_d;
  twsp_psc_state_t state_q;

  // clear beats a tick; there is no load path and no read path
  always_comb begin
    state_d = state_q;
    if (psc.clr) begin
      state_d.cnt = WIDTH'(PSC_RST);
    end else if (psc.tick) begin
      state_d.cnt = state_q.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_q.cnt <= WIDTH'(PSC_RST);
    end else begin
      state_q <= state_d;
    end
  end

  // bit n toggles every 2^n ticks, so its rise divides by 2^(n+1)
  assign psc.tap = state_q.cnt[psc.rate];
endmodule : twsp_prescaler

// File: twsp_psc_if.sv
// carrier between the timer core and the shared prescaler counter
`timescale 1ns/10ps
interface twsp_psc_if #(parameter int WIDTH = 8);
  logic                     tick;
  logic                     clr;
  logic [$clog2(WIDTH)-1:0] rate;
  logic                     tap;
  modport ctl (output tick, output clr, output rate, input tap);
  modport psc (input tick, input clr, input rate, output tap);
endinterface : twsp_psc_if

// File: twsp_pulse_src.sv
// external count source that never shortens a pin high or low time
`timescale 1ns/10ps
module twsp_pulse_src
  import twsp_pkg::*;
(
  input  wire logic clk_i,   // oscillator clock
  input  wire logic level_i, // level asked for by the bench
  output logic      pin_o    // external count pin
);
  int held;
  // a request that comes too early waits, so the minimum widths always hold
  always @(negedge clk_i) begin
    if (level_i != pin_o && held >= EXT_HALF_MIN_CYC) begin
      pin_o <= level_i;
      held  <= 1;
    end else if (held < 255) begin
      held <= held + 1;
    end
  end
  // pin starts low and ready to move
  initial begin
    pin_o = 1'b0;
    held  = 255;
  end
endmodule : twsp_pulse_src

// File: twsp_top.sv
// 8-bit timer/counter with a prescaler shared with the watchdog
`timescale 1ns/10ps
module twsp_top
  import twsp_pkg::*;
#(
  parameter int PSC_WIDTH     = 8, // prescaler width
  parameter int COUNT_PIN_BIT = 2  // direction bit of the count pin
) (
  input  wire logic       clk_i,                    // oscillator clock
  input  wire logic       sys_rst_i,                // synchronous reset, high
  input  wire logic [4:0] file_addr_i,              // file register address
  input  wire logic       file_wr_i,                // file register write
  input  wire logic       file_rd_i,                // file register read
  input  wire logic [7:0] file_wdata_i,             // write data, also w reg
  input  wire logic       option_wr_i,              // load configuration
  input  wire logic       tris_wr_i,                // load direction at addr
  input  wire logic       watchdog_clear_instr_i,   // watchdog clear executed
  input  wire logic       watchdog_tick_i,          // watchdog count pulse
  input  wire logic       external_count_input_i,   // external count pin
  output logic [7:0]      file_rdata_o,             // read data
  output logic            file_rvalid_o,            // read data valid
  output logic [7:0]      timer_count_o,            // current count
  output logic            timer_wrap_o,             // count wrapped to zero
  output logic            watchdog_timeout_o,       // postscaled watchdog
  output logic [5:0]      pin_direction_a_o,        // port a dir, 1 = input
  output logic [5:0]      pin_direction_c_o,        // port c dir, 1 = input
  output logic            wake_on_change_disable_o, // config bit 7
  output logic            weak_pullup_disable_o     // config bit 6
);

  localparam int RATE_W = $clog2(PSC_WIDTH);

  // all state of the block, apart from phase and prescaler counters, in one record
  typedef struct packed {
    logic [7:0] option;
    logic [5:0] dir_a;
    logic [5:0] dir_c;
    logic [5:0] dir_a_pin;
    logic [7:0] count;
    logic [1:0] inhibit;
    logic       ext_prev;
    logic       samp1;
    logic       samp2;
    logic       tap_prev;
    logic [7:0] rdata;
    logic       rvalid;
    logic       wdt_out;
    logic       wrap;
  } twsp_top_state_t;

  localparam twsp_top_state_t TOP_RST = '{
    option:    OPTION_RST,
    dir_a:     DIR_RST,
    dir_c:     DIR_RST,
    dir_a_pin: DIR_RST,
    count:     COUNT_RST,
    inhibit:   2'h0,
    // history starts high: the config resets to falling edges, so an idle
    // low pin reads high here and must not look like an edge after reset
    ext_prev:  1'b1,
    samp1:     1'b1,
    samp2:     1'b1,
    tap_prev:  1'b0,
    rdata:     8'h00,
    rvalid:    1'b0,
    wdt_out:   1'b0,
    wrap:      1'b0
  };

  twsp_top_state_t state_d;
  twsp_top_state_t state_q;

  logic              q2;
  logic              q4;
  logic              css;
  logic              ses;
  logic              prescaler_assign;
  logic [RATE_W-1:0] rate;
  logic              ext_lvl;
  logic              ext_edge;
  logic              src_tick;
  logic              count_wr;
  logic              sample;
  logic              sync_in;
  logic              sync_rise;
  logic              timer_step;
  logic              tap_rise;

  twsp_psc_if #(.WIDTH(PSC_WIDTH)) psc_bus ();

  // phase clocks of the instruction cycle
  twsp_phase u_phase (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .q2_o      (q2),
    .q4_o      (q4)
  );

  // the one prescaler, handed to timer or watchdog below
  twsp_prescaler #(.WIDTH(PSC_WIDTH)) u_psc (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .psc       (psc_bus.psc)
  );

  // configuration fields
  assign css  = state_q.option[OPT_CSS_BIT];
  assign ses  = state_q.option[OPT_SES_BIT];
  assign prescaler_assign  = state_q.option[OPT_PSA_BIT];
  assign rate = state_q.option[OPT_RATE_LSB +: RATE_W];

  // inverting the pin when falling edges are chosen lets one detector
  // serve both edge polarities
  assign ext_lvl  = external_count_input_i ^ ses;
  assign ext_edge = ext_lvl & ~state_q.ext_prev;

  // count source: external edges or one tick per instruction cycle
  assign src_tick = css ? ext_edge : q4;

  // software write of the count register
  assign count_wr = file_wr_i && (file_addr_i == TIMER_COUNT_ADDR);

  // prescaler steering: exactly one owner at any time
  assign psc_bus.tick = prescaler_assign ? watchdog_tick_i : src_tick;
  assign psc_bus.clr  = prescaler_assign ? watchdog_clear_instr_i : count_wr;
  assign psc_bus.rate = rate;

  // the synchroniser sees the tap, or the pin when the watchdog owns the
  // prescaler; sampling at two phases is what limits the input rate
  assign sync_in   = prescaler_assign ? ext_lvl : psc_bus.tap;
  assign sample    = q2 | q4;
  assign sync_rise = sample & state_q.samp1 & ~state_q.samp2;

  // internal source without prescaler bypasses the synchroniser
  assign timer_step = (prescaler_assign && !css) ? q4 : sync_rise;

  // watchdog postscaler output edge
  assign tap_rise = psc_bus.tap & ~state_q.tap_prev;

  // next state of the whole block
  always_comb begin
    state_d        = state_q;
    state_d.rvalid = 1'b0;
    state_d.wrap   = 1'b0;

    // edge detector history for the external pin
    state_d.ext_prev = ext_lvl;

    // two-stage sampler: capture at phase two and four only; the edge
    // appears one sample point later, which gives the fixed part of
    // the delay from pin change to count step
    if (sample) begin
      state_d.samp1 = sync_in;
      state_d.samp2 = state_q.samp1;
    end

    // configuration and direction loads from the w register
    if (option_wr_i) begin
      state_d.option = file_wdata_i;
    end
    if (tris_wr_i && (file_addr_i == DIR_A_ADDR)) begin
      state_d.dir_a = file_wdata_i[5:0];
    end
    if (tris_wr_i && (file_addr_i == DIR_C_ADDR)) begin
      state_d.dir_c = file_wdata_i[5:0];
    end

    // count pin turns input while it counts, whatever the direction
    // register holds; the register keeps its own value for later
    state_d.dir_a_pin = state_d.dir_a;
    if (state_d.option[OPT_CSS_BIT]) begin
      state_d.dir_a_pin[COUNT_PIN_BIT] = 1'b1;
    end

    // the hold-off runs out at instruction cycle ends
    if (q4 && (state_q.inhibit != 2'h0)) begin
      state_d.inhibit = state_q.inhibit - 2'h1;
    end

    // a write wins over a step in the same cycle and restarts hold-off;
    // software may preload an adjusted value to make up the lost cycles
    if (count_wr) begin
      state_d.count   = file_wdata_i;
      state_d.inhibit = WRITE_INHIBIT_CYCLES;
    end else if (timer_step && (state_q.inhibit == 2'h0)) begin
      state_d.count = state_q.count + 8'h01;
      state_d.wrap  = (state_q.count == 8'hff);
    end

    // watchdog sees the postscaled tick or, without prescaler, its own
    state_d.tap_prev = psc_bus.tap;
    state_d.wdt_out  = prescaler_assign ? tap_rise : watchdog_tick_i;

    // reads return the count before any step of this cycle; unmapped
    // addresses read as zero since other files live outside this block
    if (file_rd_i) begin
      state_d.rvalid = 1'b1;
      state_d.rdata  = (file_addr_i == TIMER_COUNT_ADDR) ? state_q.count : 8'h00;
    end
  end

  // register the whole state
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_q <= TOP_RST;
    end else begin
      state_q <= state_d;
    end
  end

  // outputs straight from the state record
  assign file_rdata_o             = state_q.rdata;
  assign file_rvalid_o            = state_q.rvalid;
  assign timer_count_o            = state_q.count;
  assign timer_wrap_o             = state_q.wrap;
  assign watchdog_timeout_o       = state_q.wdt_out;
  assign pin_direction_a_o        = state_q.dir_a_pin;
  assign pin_direction_c_o        = state_q.dir_c;
  assign wake_on_change_disable_o = state_q.option[OPT_WAKE_BIT];
  assign weak_pullup_disable_o    = state_q.option[OPT_PULL_BIT];

endmodule : twsp_top

// File: twsp_top_chk_sva.sv
// concurrent checks on the ports of the timer top
`timescale 1ns/10ps
module twsp_top_chk
  import twsp_pkg::*;
#(
  parameter int COUNT_PIN_BIT = 2 // direction bit of the count pin
) (
  input wire logic       clk_i,                    // clock
  input wire logic       sys_rst_i,                // reset
  input wire logic [4:0] file_addr_i,              // address
  input wire logic       file_wr_i,                // write
  input wire logic       file_rd_i,                // read
  input wire logic [7:0] file_wdata_i,             // write data
  input wire logic       option_wr_i,              // config load
  input wire logic       tris_wr_i,                // direction load
  input wire logic       watchdog_clear_instr_i,   // watchdog clear
  input wire logic       watchdog_tick_i,          // watchdog tick
  input wire logic       external_count_input_i,   // count pin
  input wire logic [7:0] file_rdata_o,             // read data
  input wire logic       file_rvalid_o,            // read valid
  input wire logic [7:0] timer_count_o,            // count
  input wire logic       timer_wrap_o,             // wrap pulse
  input wire logic       watchdog_timeout_o,       // time-out
  input wire logic [5:0] pin_direction_a_o,        // direction a
  input wire logic [5:0] pin_direction_c_o,        // direction c
  input wire logic       wake_on_change_disable_o, // config bit 7
  input wire logic       weak_pullup_disable_o     // config bit 6
);
  logic [7:0] cfg_q;
  logic       cnt_wr;
  logic       int_mode;
  logic       ext_mode;
  // config is write-only, so the checker keeps its own shadow copy
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) cfg_q <= OPTION_RST;
    else if (option_wr_i) cfg_q <= file_wdata_i;
  end
  // decoded modes from the shadow copy
  assign cnt_wr   = file_wr_i && (file_addr_i == TIMER_COUNT_ADDR);
  assign int_mode = !cfg_q[OPT_CSS_BIT] && cfg_q[OPT_PSA_BIT];
  assign ext_mode = cfg_q[OPT_CSS_BIT] && cfg_q[OPT_PSA_BIT];
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);
  // the selected pin edge while counting the pin directly
  sequence ext_edge_s;
    ext_mode && (cfg_q[OPT_SES_BIT] ? $fell(external_count_input_i)
                                    : $rose(external_count_input_i));
  endsequence
  // a count write followed by five quiet cycles; the hold-off covers at
  // least this long in every mode, pin-fed modes may step soon after
  sequence wr_quiet_s;
    cnt_wr ##1 (!cnt_wr)[*5];
  endsequence
  rd_answer_a: assert property (file_rd_i |=> file_rvalid_o && file_rdata_o ==
    ($past(file_addr_i) == TIMER_COUNT_ADDR ? $past(timer_count_o) : 8'h00))
    else $error("read answer wrong");
  write_hold_a: assert property (wr_quiet_s |-> timer_count_o == $past(file_wdata_i, 5))
    else $error("count moved during write hold-off");
  int_step_a: assert property (int_mode && !$past(cnt_wr) && $changed(timer_count_o)
    |-> timer_count_o == $past(timer_count_o) + 8'h01) else $error("internal step not one");
  wrap_pulse_a: assert property (timer_wrap_o == (!$past(cnt_wr) &&
    $past(timer_count_o) == 8'hff && timer_count_o == 8'h00)) else $error("wrap pulse wrong");
  pin_force_a: assert property (cfg_q[OPT_CSS_BIT] |-> pin_direction_a_o[COUNT_PIN_BIT])
    else $error("count pin not forced to input");
  wd_direct_a: assert property (!cfg_q[OPT_PSA_BIT] && !$past(cfg_q[OPT_PSA_BIT])
    |-> watchdog_timeout_o == $past(watchdog_tick_i)) else $error("watchdog tick not direct");
  ext_delay_a: assert property (ext_edge_s |=> $stable(timer_count_o) ##[1:6]
    $changed(timer_count_o)) else $error("pin edge not counted in time");
  ext_hold_a: assert property ((ext_mode && !cnt_wr && !option_wr_i &&
    $stable(external_count_input_i))[*8] |-> $stable(timer_count_o))
    else $error("count moved with idle pin");
endmodule : twsp_top_chk

bind twsp_top twsp_top_chk #(.COUNT_PIN_BIT(COUNT_PIN_BIT)) chk (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .file_addr_i(file_addr_i), .file_wr_i(file_wr_i),
  .file_rd_i(file_rd_i), .file_wdata_i(file_wdata_i), .option_wr_i(option_wr_i),
  .tris_wr_i(tris_wr_i), .watchdog_clear_instr_i(watchdog_clear_instr_i),
  .watchdog_tick_i(watchdog_tick_i), .external_count_input_i(external_count_input_i),
  .file_rdata_o(file_rdata_o), .file_rvalid_o(file_rvalid_o), .timer_count_o(timer_count_o),
  .timer_wrap_o(timer_wrap_o), .watchdog_timeout_o(watchdog_timeout_o),
  .pin_direction_a_o(pin_direction_a_o), .pin_direction_c_o(pin_direction_c_o),
  .wake_on_change_disable_o(wake_on_change_disable_o),
  .weak_pullup_disable_o(weak_pullup_disable_o)
);
